// File: design/ctt_consts.vh
// register map, field layout and timing counts of the tick timer
`ifndef CTT_CONSTS_VH
`define CTT_CONSTS_VH

`define CTT_ADDR_W        16
`define CTT_DATA_W        32

// register indices; byte address is four times the index
`define CTT_IDX_CTRL_STAT 16'h0008
`define CTT_IDX_COUNTER   16'h0009
`define CTT_IDX_EVT_STAT  16'h000a
`define CTT_IDX_EVT_CLR   16'h000b
`define CTT_IDX_EVT_EN    16'h000c
`define CTT_IDX_WDOG_SVC  16'h0ff0

// control/status fields
`define CTT_BIT_OVF_FLAG  7
`define CTT_BIT_PER_FLAG  6
`define CTT_BIT_OVF_EN    5
`define CTT_BIT_PER_EN    4
`define CTT_RATE_HI       1
`define CTT_RATE_LO       0
`define CTT_RATE_RESET    2'h3
`define CTT_WDOG_SVC_BIT  0

// event status / clear / enable fields
`define CTT_EVT_OVF       0
`define CTT_EVT_PER       1
`define CTT_EVT_WDOG      2
`define CTT_EVT_W         3

// divider chain
`define CTT_PRESC_W       2
`define CTT_CHAIN_W       15
`define CTT_TICK_W        8
`define CTT_PER_BASE      12
`define CTT_WDOG_W        3
`define CTT_WDOG_LAST     3'h7

// oscillator restart plus stabilisation delay, in bus clock cycles
`define CTT_STARTUP_CYC   4064
`define CTT_STARTUP_W     12

`endif

// File: design/ctt_chain.v
// prescaler, tick counter, periodic tap selector and watchdog divider
`timescale 1ns/1ps
module ctt_chain (
    input  wire       mclk,
    input  wire       rst_n,
    input  wire       chain_clr,
    input  wire       wdog_clr,
    input  wire [1:0] rate_sel,
    output wire [7:0] tick_count,
    output wire       ovf_evt,
    output wire       per_evt,
    output wire       wdog_evt
);
`include "ctt_consts.vh"

    reg  [`CTT_PRESC_W-1:0] presc_q;
    reg  [`CTT_CHAIN_W-1:0] chain_q;
    reg  [`CTT_WDOG_W-1:0]  wdog_q;
    wire                    tick_en;
    wire [`CTT_CHAIN_W-1:0] tap_mask;

    // all-ones test over the low 12..15 bits of the chain
    function [`CTT_CHAIN_W-1:0] ctt_tap_mask;
        input [1:0] sel;
        begin
            ctt_tap_mask = {`CTT_CHAIN_W{1'b1}} >> (2'h3 - sel);
        end
    endfunction

    assign tick_en    = (presc_q == {`CTT_PRESC_W{1'b1}});
    assign tap_mask   = ctt_tap_mask(rate_sel);
    assign tick_count = chain_q[`CTT_TICK_W-1:0];
    assign ovf_evt    = tick_en && (chain_q[`CTT_TICK_W-1:0] == 8'hff);
    // a tap change while the low bits are all ones can drop or add one event
    assign per_evt    = tick_en && ((chain_q & tap_mask) == tap_mask);
    assign wdog_evt   = per_evt && (wdog_q == `CTT_WDOG_LAST);

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            presc_q <= {`CTT_PRESC_W{1'b0}};
            chain_q <= {`CTT_CHAIN_W{1'b0}};
        end else if (chain_clr) begin
            presc_q <= {`CTT_PRESC_W{1'b0}};
            chain_q <= {`CTT_CHAIN_W{1'b0}};
        end else begin
            presc_q <= presc_q + 2'h1;
            if (tick_en) begin
                chain_q <= chain_q + 15'h0001;
            end
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wdog_q <= {`CTT_WDOG_W{1'b0}};
        end else if (chain_clr || wdog_clr) begin
            wdog_q <= {`CTT_WDOG_W{1'b0}};
        end else if (per_evt) begin
            wdog_q <= wdog_q + 3'h1;
        end
    end

endmodule // ctt_chain

// File: design/ctt_top.v
// tick timer with periodic interrupt, watchdog and apb register slave
// Summary of operation
// - reset clears both irq enables and sets rate select to 11
// - overflow flag sets when tick counter wraps from ff to 00
// - periodic flag sets when selected divider tap becomes active
// - writing zero to a set flag clears it
// - overflow enable gates overflow flag onto the interrupt request
// - periodic enable gates periodic flag onto the interrupt request
// - rate select chooses bus division 2^14, 2^15, 2^16 or 2^17
// - watchdog timeout uses same tap; seven to eight periods
// - counter register is read-only and shows the live tick count
// - reset clears the tick counter
// - chain runs during wait; enabled interrupt wakes the cpu
// - whole chain is cleared on entering stop
// - after stop wake, wait startup delay, clear chain, resume
// - tick counter advances once every four bus clocks
// - watchdog divides periodic output by eight, then resets the cpu
// - writing zero to service bit clears only the watchdog stage
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
module ctt_top #(
    parameter WDOG_PRESENT = 1
) (
    input  wire        mclk,
    input  wire        nrst,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [15:0] paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output reg  [31:0] prdata,
    output wire        pslverr,
    input  wire        stop_req,
    input  wire        ext_wake,
    output wire        irq,
    output wire        cpu_wake,
    output reg         wdog_reset,
    output wire        stopped
);
`include "ctt_consts.vh"

    // stop sequencer: running, held in stop, counting the restart delay
    localparam ST_RUN     = 2'h0;
    localparam ST_STOP    = 2'h1;
    localparam ST_RESTART = 2'h2;

    // reset release
    reg        rst_s1_q;
    reg        rst_n;

    // control/status register
    reg        ovf_flag_q;
    reg        per_flag_q;
    reg        ovf_en_q;
    reg        per_en_q;
    reg  [1:0] rate_q;
    reg        ovf_flag_d;
    reg        per_flag_d;
    reg        ovf_en_d;
    reg        per_en_d;
    reg  [1:0] rate_d;
    wire       ctrl_wr;

    // event status and enable
    reg  [`CTT_EVT_W-1:0] evt_stat_q;
    reg  [`CTT_EVT_W-1:0] evt_en_q;
    reg  [`CTT_EVT_W-1:0] evt_stat_d;

    // wake pin synchroniser
    reg        wake_s1_q;
    reg        wake_s2_q;
    reg        wake_s3_q;
    reg        wake_lvl_q;

    // stop sequencing
    reg  [1:0]                 st_q;
    reg  [1:0]                 st_d;
    reg  [`CTT_STARTUP_W-1:0]  dly_q;
    reg  [`CTT_STARTUP_W-1:0]  dly_d;
    reg                        stop_req_q;
    reg                        chain_clr;
    reg                        stopped_q;

    wire [7:0] tick_count;
    wire       ovf_evt;
    wire       per_evt;
    wire       wdog_evt;
    wire       wdog_fire;

    // bus decode
    wire        wr_en;
    wire        rd_setup;
    wire [15:0] idx;
    wire        hit_cs;
    wire        hit_cnt;
    wire        hit_stat;
    wire        hit_clr;
    wire        hit_en;
    wire        hit_svc;
    wire        mapped;
    wire        wdog_clr;
    reg  [31:0] rd_mux;

    function ctt_hit;
        input [15:0] a;
        input [15:0] index;
        begin
            ctt_hit = (a[15:2] == index[13:0]) && (a[1:0] == 2'h0);
        end
    endfunction

    // two-flop reset release; assertion stays asynchronous
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    ctt_chain u_chain (
        .mclk       (mclk),
        .rst_n      (rst_n),
        .chain_clr  (chain_clr),
        .wdog_clr   (wdog_clr),
        .rate_sel   (rate_q),
        .tick_count (tick_count),
        .ovf_evt    (ovf_evt),
        .per_evt    (per_evt),
        .wdog_evt   (wdog_evt)
    );

    // timeout can be left out at build time; the divider keeps running anyway
    assign wdog_fire = wdog_evt && (WDOG_PRESENT != 0);

    // zero-wait apb slave; read data is latched in the setup cycle
    assign pready   = 1'b1;
    assign idx      = paddr;
    assign hit_cs   = ctt_hit(idx, `CTT_IDX_CTRL_STAT);
    assign hit_cnt  = ctt_hit(idx, `CTT_IDX_COUNTER);
    assign hit_stat = ctt_hit(idx, `CTT_IDX_EVT_STAT);
    assign hit_clr  = ctt_hit(idx, `CTT_IDX_EVT_CLR);
    assign hit_en   = ctt_hit(idx, `CTT_IDX_EVT_EN);
    assign hit_svc  = ctt_hit(idx, `CTT_IDX_WDOG_SVC);
    assign mapped   = hit_cs | hit_cnt | hit_stat | hit_clr | hit_en | hit_svc;
    // unmapped offsets answer with an error and leave every register alone
    assign pslverr  = psel && penable && !mapped;
    assign wr_en    = psel && penable && pwrite && mapped;
    assign ctrl_wr  = wr_en && hit_cs;
    assign rd_setup = psel && !penable && !pwrite;
    assign wdog_clr = wr_en && hit_svc && !pwdata[`CTT_WDOG_SVC_BIT];

    always @* begin
        rd_mux = 32'h0000_0000;
        if (hit_cs) begin
            rd_mux[`CTT_BIT_OVF_FLAG] = ovf_flag_q;
            rd_mux[`CTT_BIT_PER_FLAG] = per_flag_q;
            rd_mux[`CTT_BIT_OVF_EN]   = ovf_en_q;
            rd_mux[`CTT_BIT_PER_EN]   = per_en_q;
            rd_mux[`CTT_RATE_HI]      = rate_q[1];
            rd_mux[`CTT_RATE_LO]      = rate_q[0];
        end else if (hit_cnt) begin
            rd_mux[7:0] = tick_count;
        end else if (hit_stat) begin
            rd_mux[`CTT_EVT_W-1:0] = evt_stat_q;
        end else if (hit_en) begin
            rd_mux[`CTT_EVT_W-1:0] = evt_en_q;
        end
    end

    // sampled in setup, so a counter read shows the count one clock early
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= rd_mux;
        end
    end

    // control/status next state; a hardware set beats a same-cycle clear
    always @* begin
        ovf_flag_d = ovf_flag_q;
        per_flag_d = per_flag_q;
        ovf_en_d   = ovf_en_q;
        per_en_d   = per_en_q;
        rate_d     = rate_q;
        if (ctrl_wr) begin
            // a written one leaves a flag alone; only a zero clears it
            ovf_flag_d = ovf_flag_q & pwdata[`CTT_BIT_OVF_FLAG];
            per_flag_d = per_flag_q & pwdata[`CTT_BIT_PER_FLAG];
            ovf_en_d   = pwdata[`CTT_BIT_OVF_EN];
            per_en_d   = pwdata[`CTT_BIT_PER_EN];
            // no guard on a live tap change: software services watchdog first
            rate_d     = pwdata[`CTT_RATE_HI:`CTT_RATE_LO];
        end
        if (ovf_evt) begin
            ovf_flag_d = 1'b1;
        end
        if (per_evt) begin
            per_flag_d = 1'b1;
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ovf_flag_q <= 1'b0;
            per_flag_q <= 1'b0;
            ovf_en_q   <= 1'b0;
            per_en_q   <= 1'b0;
            rate_q     <= `CTT_RATE_RESET;
        end else begin
            ovf_flag_q <= ovf_flag_d;
            per_flag_q <= per_flag_d;
            ovf_en_q   <= ovf_en_d;
            per_en_q   <= per_en_d;
            rate_q     <= rate_d;
        end
    end

    // sticky event status, cleared by writing ones to the clear register
    always @* begin
        evt_stat_d = evt_stat_q;
        if (wr_en && hit_clr) begin
            evt_stat_d = evt_stat_q & ~pwdata[`CTT_EVT_W-1:0];
        end
        if (ovf_evt) begin
            evt_stat_d[`CTT_EVT_OVF] = 1'b1;
        end
        if (per_evt) begin
            evt_stat_d[`CTT_EVT_PER] = 1'b1;
        end
        if (wdog_fire) begin
            evt_stat_d[`CTT_EVT_WDOG] = 1'b1;
        end
    end

    // status bits are sticky; only the clear register or reset drops them
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            evt_stat_q <= {`CTT_EVT_W{1'b0}};
            evt_en_q   <= {`CTT_EVT_W{1'b0}};
        end else begin
            evt_stat_q <= evt_stat_d;
            if (wr_en && hit_en) begin
                evt_en_q <= pwdata[`CTT_EVT_W-1:0];
            end
        end
    end

    // level request, held until software clears the flag
    assign irq = (ovf_flag_q & ovf_en_q)
               | (per_flag_q & per_en_q)
               | (|(evt_stat_q & evt_en_q));
    // the chain never stops for wait, so any enabled request wakes the cpu
    assign cpu_wake = irq;

    // watchdog timeout drives a one-cycle internal reset request
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wdog_reset <= 1'b0;
        end else begin
            wdog_reset <= wdog_fire;
        end
    end

    // external wake pin: a change counts once stages two and three agree
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wake_s1_q  <= 1'b0;
            wake_s2_q  <= 1'b0;
            wake_s3_q  <= 1'b0;
            wake_lvl_q <= 1'b0;
        end else begin
            wake_s1_q <= ext_wake;
            wake_s2_q <= wake_s1_q;
            wake_s3_q <= wake_s2_q;
            if (wake_s2_q == wake_s3_q) begin
                wake_lvl_q <= wake_s3_q;
            end
        end
    end

    // stop entry is taken on the rising edge of the cpu's stop request
    always @* begin
        st_d      = st_q;
        dly_d     = dly_q;
        chain_clr = 1'b0;
        case (st_q)
            ST_RUN: begin
                if (stop_req && !stop_req_q) begin
                    st_d      = ST_STOP;
                    chain_clr = 1'b1;
                end
            end
            ST_STOP: begin
                chain_clr = 1'b1;
                if (wake_lvl_q) begin
                    st_d  = ST_RESTART;
                    dly_d = {`CTT_STARTUP_W{1'b0}};
                end
            end
            ST_RESTART: begin
                chain_clr = 1'b1;
                if (dly_q == `CTT_STARTUP_CYC - 1) begin
                    st_d = ST_RUN;
                end else begin
                    dly_d = dly_q + 12'h001;
                end
            end
            default: begin
                st_d      = ST_RUN;
                chain_clr = 1'b1;
            end
        endcase
    end

    // reset exits stop as well, since it returns the sequencer to run
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            st_q       <= ST_RUN;
            dly_q      <= {`CTT_STARTUP_W{1'b0}};
            stop_req_q <= 1'b0;
        end else begin
            st_q       <= st_d;
            dly_q      <= dly_d;
            stop_req_q <= stop_req;
        end
    end

    // registered from the next state, so it moves on the same edge as st_q
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stopped_q <= 1'b0;
        end else begin
            stopped_q <= (st_d != ST_RUN);
        end
    end

    assign stopped = stopped_q;

endmodule // ctt_top

// File: testbench/ctt_top_asserts.sv
// port-level assertion checker for the tick timer
`timescale 1ns/1ps
module ctt_top_asserts (
    input wire logic        mclk,
    input wire logic        nrst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        stop_req,
    input wire logic        ext_wake,
    input wire logic        irq,
    input wire logic        cpu_wake,
    input wire logic        wdog_reset,
    input wire logic        stopped
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    sequence s_rd_setup;
        psel && !penable && !pwrite;
    endsequence
    sequence s_ctrl_rd;
        s_rd_setup ##0 paddr == 16'h0020;
    endsequence
    sequence s_wake;
        stopped && $rose(ext_wake);
    endsequence
    a_ready_high: assert property (pready)
        else $error("pready low");
    a_wake_irq: assert property (cpu_wake == irq)
        else $error("wake differs from irq");
    a_err_unmap: assert property (psel && penable && paddr == 16'h0040 |-> pslverr)
        else $error("no error on unmapped access");
    a_err_mapped: assert property (psel && penable && paddr == 16'h0024 |-> !pslverr)
        else $error("error on counter access");
    a_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
        else $error("read data moved");
    a_irq_flag: assert property (s_ctrl_rd ##1
        (prdata[7] && prdata[5] || prdata[6] && prdata[4]) |-> irq)
        else $error("enabled flag without irq");
    a_wdog_pulse: assert property (wdog_reset |=> !wdog_reset)
        else $error("watchdog pulse too long");
    a_stop_enter: assert property ($rose(stop_req) && !stopped |-> ##[1:2] stopped)
        else $error("stop not entered");
    a_stop_hold: assert property (s_wake |=> stopped [*8])
        else $error("restart delay too short");
endmodule // ctt_top_asserts

// File: testbench/ctt_cpu_model.sv
// cpu core model: counts interrupts, sleeps in wait, requests stop
`timescale 1ns/1ps
module ctt_cpu_model (
    input  wire logic mclk,
    input  wire logic rst_n,
    input  wire logic irq,
    input  wire logic cpu_wake,
    input  wire logic stop_cmd,
    input  wire logic wait_cmd,
    output logic      stop_req,
    output logic      asleep,
    output int        n_irq
);
    logic irq_q;
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            stop_req <= 1'b0;
            asleep <= 1'b0;
            n_irq <= 0;
            irq_q <= 1'b0;
        end else begin
            stop_req <= stop_cmd;
            // a live wake wins: the core cannot sleep on a pending irq
            if (cpu_wake) begin
                asleep <= 1'b0;
            end else if (wait_cmd) begin
                asleep <= 1'b1;
            end
            irq_q <= irq;
            if (irq && !irq_q) begin
                n_irq <= n_irq + 1;
            end
        end
    end
endmodule // ctt_cpu_model

// File: testbench/ctt_tb_top.sv
// tick timer testbench: apb scenarios, cpu model and checker bind
`timescale 1ns/1ps
`include "ctt_consts.vh"
module ctt_tb_top;
    localparam logic [15:0] A_CTRL = `CTT_IDX_CTRL_STAT << 2;
    localparam logic [15:0] A_CNT  = `CTT_IDX_COUNTER << 2;
    localparam logic [15:0] A_STAT = `CTT_IDX_EVT_STAT << 2;
    localparam logic [15:0] A_CLR  = `CTT_IDX_EVT_CLR << 2;
    localparam logic [15:0] A_EN   = `CTT_IDX_EVT_EN << 2;
    localparam logic [15:0] A_SVC  = `CTT_IDX_WDOG_SVC << 2;
    logic        mclk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        stop_cmd = 1'b0, wait_cmd = 1'b0, ext_wake = 1'b0;
    logic [15:0] paddr = 16'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, irq, cpu_wake, wdog_reset, stopped, stop_req, asleep, er;
    int          n_irq, cnt, n_errors = 0, num_checks = 0;

    always #2.5 mclk = ~mclk;

    ctt_top dut (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .stop_req(stop_req), .ext_wake(ext_wake), .irq(irq), .cpu_wake(cpu_wake),
        .wdog_reset(wdog_reset), .stopped(stopped));
    ctt_cpu_model u_cpu (.mclk(mclk), .rst_n(nrst), .irq(irq), .cpu_wake(cpu_wake),
        .stop_cmd(stop_cmd), .wait_cmd(wait_cmd), .stop_req(stop_req), .asleep(asleep),
        .n_irq(n_irq));

    task wrap_up;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // one transfer; the request stands until pready is seen high
    task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
        int i;
        @(posedge mclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge mclk);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            chk({31'h0, pready}, 32'h1);
            wrap_up;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // cnt returns the number of edges until irq is seen
    task wait_irq(input int n);
        for (cnt = 0; cnt < n; cnt++) begin
            @(posedge mclk);
            if (irq === 1'b1) break;
        end
        if (cnt == n) begin
            chk({31'h0, irq}, 32'h1);
            wrap_up;
        end
        cnt = cnt + 1;
    endtask

    task t_regs;
        logic [31:0] v;
        apb(1'b0, A_CTRL, 32'h0);
        chk(rd, 32'h3);
        apb(1'b0, 16'h0040, 32'h0);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        apb(1'b0, A_CNT, 32'h0);
        v = rd;
        apb(1'b1, A_CNT, 32'hff);
        apb(1'b1, A_SVC, 32'h0);
        // read setup edges end up 64 clocks apart; neither write may move the count
        repeat (55) @(posedge mclk);
        apb(1'b0, A_CNT, 32'h0);
        chk(rd, (v + 32'h10) & 32'hff);
    endtask

    task t_events;
        apb(1'b1, A_CTRL, 32'h0);
        apb(1'b1, A_CLR, 32'h7);
        apb(1'b1, A_EN, 32'h1);
        @(posedge mclk) wait_cmd <= 1'b1;
        @(posedge mclk) wait_cmd <= 1'b0;
        #1 chk({31'h0, asleep}, 32'h1);
        wait_irq(1100);
        @(posedge mclk) #1 chk({31'h0, asleep}, 32'h0);
        apb(1'b0, A_STAT, 32'h0);
        chk(rd & 32'h1, 32'h1);
        apb(1'b1, A_CLR, 32'h1);
        #1 chk({31'h0, irq}, 32'h0);
        apb(1'b0, A_CLR, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, A_EN, 32'h0);
    endtask

    task t_measure(input logic [7:0] c, input int per);
        int b;
        apb(1'b1, A_SVC, 32'h0);
        apb(1'b1, A_CTRL, {24'h0, c});
        wait_irq(per + 8);
        apb(1'b1, A_CTRL, {24'h0, c});
        #1 chk({31'h0, irq}, 32'h0);
        b = n_irq;
        wait_irq(per + 8);
        chk(32'(cnt + 3), 32'(per));
        #1 chk(32'(n_irq - b), 32'h1);
    endtask

    task t_mask;
        apb(1'b1, A_CTRL, 32'hc0);
        #1 chk({31'h0, irq}, 32'h0);
        apb(1'b1, A_CTRL, 32'he0);
        #1 chk({31'h0, irq}, 32'h1);
        // overflow flag survived the written ones; periodic flag still clear
        apb(1'b0, A_CTRL, 32'h0);
        chk(rd, 32'ha0);
    endtask

    task t_stop;
        int i;
        @(posedge mclk) stop_cmd <= 1'b1;
        repeat (3) @(posedge mclk);
        #1 chk({31'h0, stopped}, 32'h1);
        apb(1'b0, A_CNT, 32'h0);
        chk(rd, 32'h0);
        @(posedge mclk) ext_wake <= 1'b1;
        for (i = 0; i < 4200; i++) begin
            @(posedge mclk);
            if (stopped === 1'b0) break;
        end
        chk(32'(i >= 4064 && i <= 4076), 32'h1);
        apb(1'b0, A_CNT, 32'h0);
        chk(rd >> 2, 32'h0);
        ext_wake <= 1'b0;
        stop_cmd <= 1'b0;
    endtask

    initial begin
        repeat (8) @(posedge mclk);
        nrst <= 1'b1;
        repeat (3) @(posedge mclk);
        t_regs;
        t_events;
        t_measure(8'h20, 1024);
        t_mask;
        t_measure(8'h10, 16384);
        t_measure(8'h11, 32768);
        t_stop;
        wrap_up;
    end
endmodule // ctt_tb_top

bind ctt_top ctt_top_asserts u_chk (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .stop_req(stop_req), .ext_wake(ext_wake), .irq(irq),
    .cpu_wake(cpu_wake), .wdog_reset(wdog_reset), .stopped(stopped));
